// ---- design/flt_defines.vh ----
// Register map, field positions and reset values for the fan table entries three and four
`ifndef FLT_DEFINES_VH
`define FLT_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (printed offsets, byte address is index times four)
// ----------------------------------------------------------------
`define FLT_IDX_THRESH3 8'h54
`define FLT_IDX_DUTY3 8'h55
`define FLT_IDX_THRESH4 8'h56
`define FLT_IDX_DUTY4 8'h57
`define FLT_IDX_CTRL 8'h4A

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FLT_RST_THRESH 8'h7F
`define FLT_RST_DUTY 8'h3F
`define FLT_RST_CTRL 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FLT_HALF_BIT 7
`define FLT_WHOLE_MSB 6
`define FLT_EXT_MSB 7
`define FLT_EXT_LSB 6
`define FLT_BASE_MSB 5
`define FLT_CTRL_WREN 5
`define FLT_CTRL_TEMP_HIRES 0
`define FLT_CTRL_DUTY_HIRES 1
`define FLT_CTRL_FAST_PWM 2

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define FLT_HTRANS_NONSEQ 2'h2
`define FLT_HTRANS_SEQ 2'h3
`define FLT_ADDR_LSB 2
`define FLT_ADDR_IDX_MSB 9
`define FLT_HADDR_MSB 31
`define FLT_HSIZE_WORD 3'h2

`endif

// ---- design/flt_fan_table.v ----
// Fan speed table entries three and four with AHB-Lite register access and threshold compare
//
// Implementation choice: the AHB-Lite register port.
`include "flt_defines.vh"

// Overview of operation
// RULE1 - Low temp mode: threshold top bit reads zero
// RULE2 - High temp mode: nine-bit threshold, half degrees
// RULE3 - Low temp mode: seven-bit threshold, whole degrees
// RULE4 - Temperature above threshold selects paired duty
// RULE5 - Compare nine bits high, eight bits low
// RULE6 - Thresholds unsigned, sign bit assumed zero
// RULE7 - Table offset extends threshold range upward
// RULE8 - Low duty mode: extended bits read zero
// RULE9 - High duty mode: extended bits above base
// RULE10 - Extended duty only with fast PWM
// RULE11 - Low duty mode: six-bit base only
// RULE12 - Writes need control write-enable bit five; the control register itself is written without it
module flt_fan_table #(
   parameter TEMP_W = 9,
   parameter DUTY_W = 8
) (
   // Clock and reset
   input wire CLK_I,
   input wire SRST_I,
   // AHB-Lite slave
   input wire HSEL_I,
   input wire [31:0] HADDR_I,
   input wire [1:0] HTRANS_I,
   input wire HWRITE_I,
   input wire [2:0] HSIZE_I,
   input wire [31:0] HWDATA_I,
   input wire HREADY_I,
   output wire [31:0] HRDATA_O,
   output wire HREADYOUT_O,
   output wire HRESP_O,
   // Temperature and offset from the measurement side
   input wire [TEMP_W-1:0] REMOTE_TEMP_I,
   input wire [7:0] TABLE_OFFSET_I,
   // Fan duty request
   output wire [DUTY_W-1:0] PWM_DUTY_O,
   output wire PWM_DUTY_VALID_O
);

   // ----------------------------------------------------------------
   // Derived widths and slots
   // ----------------------------------------------------------------
   // The compare runs two bits wider than the reading so the offset sum cannot wrap
   localparam CMP_W = TEMP_W + 2;
   localparam THR_PAD = CMP_W - 8;
   localparam LIFT_PAD = CMP_W - 9;
   localparam TEMP_PAD = CMP_W - TEMP_W;
   localparam N_ENTRY = 2;
   // One-hot write select, decoded in the address phase
   localparam SEL_W = 5;
   localparam SEL_THRESH3 = 0;
   localparam SEL_DUTY3 = 1;
   localparam SEL_THRESH4 = 2;
   localparam SEL_DUTY4 = 3;
   localparam SEL_CTRL = 4;

   reg [7:0] thresh3;
   reg [7:0] duty3;
   reg [7:0] thresh4;
   reg [7:0] duty4;
   reg [7:0] ctrl;
   reg wr_pend;
   reg [SEL_W-1:0] wr_sel;
   reg [31:0] rdata;
   reg [DUTY_W-1:0] duty_out;
   reg duty_valid;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // Extended duty bits need both the duty mode bit and the fast PWM select
   wire temp_hires = ctrl[`FLT_CTRL_TEMP_HIRES];
   wire duty_hires = ctrl[`FLT_CTRL_DUTY_HIRES] & ctrl[`FLT_CTRL_FAST_PWM]; // RULE10
   wire wr_enable = ctrl[`FLT_CTRL_WREN];

   // ----------------------------------------------------------------
   // Bus address phase
   // ----------------------------------------------------------------
   // Only whole aligned words inside the decoded window reach a register;
   // anything else is still answered OKAY but reads zero and writes nothing
   wire trans_valid = (HTRANS_I == `FLT_HTRANS_NONSEQ) | (HTRANS_I == `FLT_HTRANS_SEQ);
   wire active = HSEL_I & HREADY_I & trans_valid;
   wire [7:0] addr_idx = HADDR_I[`FLT_ADDR_IDX_MSB:`FLT_ADDR_LSB];
   wire addr_upper_zero = ~|HADDR_I[`FLT_HADDR_MSB:`FLT_ADDR_IDX_MSB+1];
   wire addr_aligned = ~|HADDR_I[`FLT_ADDR_LSB-1:0];
   wire size_word = (HSIZE_I == `FLT_HSIZE_WORD);
   wire addr_ok = addr_upper_zero & addr_aligned & size_word;

   // Decode once here; the data phase then needs no address compare
   wire [SEL_W-1:0] addr_hit;
   assign addr_hit[SEL_THRESH3] = addr_ok & (addr_idx == `FLT_IDX_THRESH3);
   assign addr_hit[SEL_DUTY3] = addr_ok & (addr_idx == `FLT_IDX_DUTY3);
   assign addr_hit[SEL_THRESH4] = addr_ok & (addr_idx == `FLT_IDX_THRESH4);
   assign addr_hit[SEL_DUTY4] = addr_ok & (addr_idx == `FLT_IDX_DUTY4);
   assign addr_hit[SEL_CTRL] = addr_ok & (addr_idx == `FLT_IDX_CTRL);

   // ----------------------------------------------------------------
   // Write decode, one strobe per register, used in the data phase
   // ----------------------------------------------------------------
   wire wr_ctrl = wr_pend & wr_sel[SEL_CTRL];
   wire wr_entry = wr_pend & wr_enable; // RULE12
   wire wr_thresh3 = wr_entry & wr_sel[SEL_THRESH3];
   wire wr_duty3 = wr_entry & wr_sel[SEL_DUTY3];
   wire wr_thresh4 = wr_entry & wr_sel[SEL_THRESH4];
   wire wr_duty4 = wr_entry & wr_sel[SEL_DUTY4];
   wire [7:0] wdata = HWDATA_I[7:0];

   // ----------------------------------------------------------------
   // Bus response
   // ----------------------------------------------------------------
   // Zero-wait slave: every transfer completes in its first data cycle
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   assign HRDATA_O = rdata;

   // ----------------------------------------------------------------
   // Read view: unused bits of the current mode read as zero
   // ----------------------------------------------------------------
   // Entry views are built in the per-entry loop further down
   wire [8*N_ENTRY-1:0] tview_bus;
   wire [8*N_ENTRY-1:0] dview_bus;
   wire [7:0] thresh3_view = tview_bus[0 +: 8];
   wire [7:0] duty3_view = dview_bus[0 +: 8];
   wire [7:0] thresh4_view = tview_bus[8 +: 8];
   wire [7:0] duty4_view = dview_bus[8 +: 8];

   reg [7:0] rd_sel;
   always @* begin
      rd_sel = 8'h00;
      if (addr_ok) begin
         case (addr_idx)
            `FLT_IDX_THRESH3: rd_sel = thresh3_view;
            `FLT_IDX_DUTY3: rd_sel = duty3_view;
            `FLT_IDX_THRESH4: rd_sel = thresh4_view;
            `FLT_IDX_DUTY4: rd_sel = duty4_view;
            `FLT_IDX_CTRL: rd_sel = ctrl;
            default: rd_sel = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Bus pipeline and register storage
   // ----------------------------------------------------------------
   // Remembers a write address phase for its data phase one cycle later
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         wr_pend <= 1'b0;
         wr_sel <= {SEL_W{1'b0}};
      end else begin
         wr_pend <= active & HWRITE_I;
         wr_sel <= addr_hit;
      end
   end

   // Read data is taken in the address phase and stands through the data phase
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         rdata <= 32'h0000_0000;
      end else if (active & ~HWRITE_I) begin
         rdata <= {24'h00_0000, rd_sel};
      end
   end

   // Control is always writable, otherwise a locked table could never be opened
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         ctrl <= `FLT_RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl <= wdata;
      end
   end

   // Table entries are locked unless the enable bit is set
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         thresh3 <= `FLT_RST_THRESH;
      end else if (wr_thresh3) begin
         thresh3 <= wdata;
      end
   end

   always @(posedge CLK_I) begin
      if (SRST_I) begin
         duty3 <= `FLT_RST_DUTY;
      end else if (wr_duty3) begin
         duty3 <= wdata;
      end
   end

   always @(posedge CLK_I) begin
      if (SRST_I) begin
         thresh4 <= `FLT_RST_THRESH;
      end else if (wr_thresh4) begin
         thresh4 <= wdata;
      end
   end

   always @(posedge CLK_I) begin
      if (SRST_I) begin
         duty4 <= `FLT_RST_DUTY;
      end else if (wr_duty4) begin
         duty4 <= wdata;
      end
   end

   // ----------------------------------------------------------------
   // Threshold compare
   // ----------------------------------------------------------------
   // Thresholds are held in half degrees, nine bits, unsigned; offset in whole degrees
   function [CMP_W-1:0] eff_thresh;
      input [7:0] raw;
      input hires;
      input [7:0] offs;
      reg [CMP_W-1:0] base;
      reg [CMP_W-1:0] lift;
      begin
         if (hires) begin
            base = {{THR_PAD{1'b0}}, raw[`FLT_WHOLE_MSB:0], raw[`FLT_HALF_BIT]}; // RULE2 RULE6
         end else begin
            base = {{THR_PAD{1'b0}}, raw[`FLT_WHOLE_MSB:0], 1'b0}; // RULE3 RULE6
         end
         // Offset counts whole degrees, so it sits one bit up
         lift = {{LIFT_PAD{1'b0}}, offs, 1'b0}; // RULE7
         eff_thresh = base + lift;
      end
   endfunction

   function [DUTY_W-1:0] duty_val;
      input [7:0] raw;
      input hires;
      begin
         if (hires) begin
            duty_val = raw; // RULE9
         end else begin
            duty_val = {2'h0, raw[`FLT_BASE_MSB:0]}; // RULE11
         end
      end
   endfunction

   // Temperature in half degrees; low mode drops the half-degree bit
   wire [CMP_W-1:0] temp_cmp = temp_hires ? {{TEMP_PAD{1'b0}}, REMOTE_TEMP_I} :
      {{TEMP_PAD{1'b0}}, REMOTE_TEMP_I[TEMP_W-1:1], 1'b0}; // RULE5

   // ----------------------------------------------------------------
   // Per-entry limit, view and duty; entry three in slot 0, four in slot 1
   // ----------------------------------------------------------------
   wire [8*N_ENTRY-1:0] thresh_bus = {thresh4, thresh3};
   wire [8*N_ENTRY-1:0] duty_bus = {duty4, duty3};
   wire [DUTY_W*N_ENTRY-1:0] dval_bus;
   wire [N_ENTRY-1:0] over;

   genvar g;
   generate
      for (g = 0; g < N_ENTRY; g = g + 1) begin : g_entry
         wire [7:0] thr = thresh_bus[8*g +: 8];
         wire [7:0] dty = duty_bus[8*g +: 8];
         wire [CMP_W-1:0] lim = eff_thresh(thr, temp_hires, TABLE_OFFSET_I);
         // Stored bits are kept; only the view of the current mode hides them
         assign tview_bus[8*g +: 8] = temp_hires ? thr : {1'b0, thr[`FLT_WHOLE_MSB:0]}; // RULE1
         assign dview_bus[8*g +: 8] = duty_hires ? dty : {2'h0, dty[`FLT_BASE_MSB:0]}; // RULE8
         assign dval_bus[DUTY_W*g +: DUTY_W] = duty_val(dty, duty_hires); // RULE9 RULE11
         assign over[g] = temp_cmp > lim; // RULE4
      end
   endgenerate

   // ----------------------------------------------------------------
   // Registered duty request
   // ----------------------------------------------------------------
   // Higher entry wins when both are exceeded
   reg [DUTY_W-1:0] next_duty_out;
   reg next_duty_valid;
   always @* begin
      next_duty_valid = |over; // RULE4
      if (over[1]) begin
         next_duty_out = dval_bus[DUTY_W +: DUTY_W]; // RULE4
      end else if (over[0]) begin
         next_duty_out = dval_bus[0 +: DUTY_W]; // RULE4
      end else begin
         next_duty_out = {DUTY_W{1'b0}};
      end
   end

   always @(posedge CLK_I) begin
      if (SRST_I) begin
         duty_out <= {DUTY_W{1'b0}};
         duty_valid <= 1'b0;
      end else begin
         duty_out <= next_duty_out;
         duty_valid <= next_duty_valid;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign PWM_DUTY_O = duty_out;
   assign PWM_DUTY_VALID_O = duty_valid;

endmodule // flt_fan_table

// ---- verif/fan_lut_entries_three_four_test.sv ----
// Self-checking bench for the fan table entries three and four
module fan_lut_entries_three_four_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_I = 0, SRST_I = 1, HSEL_I = 0, HWRITE_I = 0;
   logic [31:0] HADDR_I = 0, HWDATA_I = 0;
   logic [1:0] HTRANS_I = 0;
   logic [2:0] HSIZE_I = 3'h2;
   logic [8:0] REMOTE_TEMP_I = 0;
   logic [7:0] TABLE_OFFSET_I = 0;
   wire [7:0] PWM_DUTY_O;
   wire [31:0] HRDATA_O;
   wire HREADYOUT_O, HRESP_O, PWM_DUTY_VALID_O;
   wire HREADY_I = HREADYOUT_O;
   int err_total = 0, n_compared = 0;
   flt_fan_table dut_u (.*);
   always #12.5 CLK_I = ~CLK_I;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Single word transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      HSEL_I <= 1;
      HTRANS_I <= 2'h2;
      HWRITE_I <= w;
      HADDR_I <= {22'h0, idx, 2'h0};
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      HTRANS_I <= 2'h0;
      HSEL_I <= 0;
      HWDATA_I <= d;
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      if (!w) chk(HRDATA_O, d);
   endtask
   // Output is registered, so give the compare a few edges to settle
   task automatic duty(input logic [8:0] t, input logic v, input logic [7:0] d);
      REMOTE_TEMP_I <= t;
      repeat (3) @(posedge CLK_I);
      chk({23'h0, PWM_DUTY_VALID_O, PWM_DUTY_O}, {23'h0, v, d});
   endtask
   task automatic t_reset;
      bus(0, 8'h54, 32'h7F);
      bus(0, 8'h55, 32'h3F);
      bus(0, 8'h56, 32'h7F);
      bus(0, 8'h57, 32'h3F);
      bus(0, 8'h4A, 32'h0);
      bus(0, 8'h40, 32'h0);
   endtask
   task automatic t_lock;
      bus(1, 8'h54, 32'h10);
      bus(0, 8'h54, 32'h7F);
      bus(1, 8'h4A, 32'h20);
      bus(1, 8'h54, 32'h8A);
      bus(0, 8'h54, 32'h0A);
      bus(1, 8'h4A, 32'h21);
      bus(0, 8'h54, 32'h8A);
   endtask
   task automatic t_compare;
      bus(1, 8'h54, 32'h94);
      bus(1, 8'h55, 32'hC5);
      bus(1, 8'h56, 32'h1E);
      bus(1, 8'h57, 32'h0A);
      duty(9'd41, 0, 8'h00);
      duty(9'd42, 1, 8'h05);
      duty(9'd61, 1, 8'h0A);
      bus(1, 8'h4A, 32'h20);
      duty(9'd41, 0, 8'h00);
      duty(9'd42, 1, 8'h05);
      TABLE_OFFSET_I <= 8'h0A;
      duty(9'd42, 0, 8'h00);
      duty(9'd62, 1, 8'h05);
      TABLE_OFFSET_I <= 8'h00;
      duty(9'd0, 0, 8'h00);
      duty(9'h1FF, 1, 8'h0A);
   endtask
   task automatic t_duty_modes;
      bus(1, 8'h4A, 32'h22);
      duty(9'd42, 1, 8'h05);
      bus(0, 8'h55, 32'h05);
      bus(1, 8'h4A, 32'h26);
      duty(9'd42, 1, 8'hC5);
      bus(0, 8'h55, 32'hC5);
      bus(1, 8'h4A, 32'h06);
      bus(1, 8'h55, 32'h00);
      bus(0, 8'h55, 32'hC5);
   endtask
   task automatic tally_and_finish;
      $display("errors %0d compares %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge CLK_I);
      SRST_I <= 0;
      @(posedge CLK_I);
      t_reset();
      t_lock();
      t_compare();
      t_duty_modes();
      tally_and_finish();
   end
   // About 90 cycles expected; far beyond that means a hang
   initial begin
      #50us;
      err_total++;
      tally_and_finish();
   end
endmodule // fan_lut_entries_three_four_test

// ---- verif/flt_fan_table_properties.sv ----
// Port assertions for the fan table
module flt_fan_table_properties #(parameter TEMP_W = 9, parameter DUTY_W = 8) (
   input wire CLK_I,
   input wire SRST_I,
   input wire HSEL_I,
   input wire [1:0] HTRANS_I,
   input wire HWRITE_I,
   input wire HREADY_I,
   input wire [31:0] HRDATA_O,
   input wire HREADYOUT_O,
   input wire HRESP_O,
   input wire [TEMP_W-1:0] REMOTE_TEMP_I,
   input wire [7:0] TABLE_OFFSET_I,
   input wire [DUTY_W-1:0] PWM_DUTY_O,
   input wire PWM_DUTY_VALID_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   wire rd_take = HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I;
   // Full-scale reading beats any threshold when no offset lifts it
   sequence hot_seen;
      REMOTE_TEMP_I == '1 && TABLE_OFFSET_I == 8'h00;
   endsequence
   a_ready_high: assert property (HREADYOUT_O) else $error("ready low");
   a_resp_okay: assert property (!HRESP_O) else $error("resp not okay");
   a_rdata_upper: assert property (HRDATA_O[31:8] == 24'h0) else $error("upper rdata");
   a_rdata_hold: assert property (!rd_take |=> $stable(HRDATA_O)) else $error("rdata moved");
   a_idle_duty: assert property (!PWM_DUTY_VALID_O |-> PWM_DUTY_O == 0) else $error("idle duty");
   a_reset_clears: assert property ($fell(SRST_I) |-> !PWM_DUTY_VALID_O && HRDATA_O == 0)
      else $error("reset outputs");
   a_cold_idle: assert property (REMOTE_TEMP_I == 0 |=> !PWM_DUTY_VALID_O) else $error("cold");
   a_hot_valid: assert property (hot_seen |=> PWM_DUTY_VALID_O) else $error("hot");
endmodule // flt_fan_table_properties

bind flt_fan_table flt_fan_table_properties #(.TEMP_W(TEMP_W), .DUTY_W(DUTY_W)) chk_u (.*);
